// >>> inc/dasr_pkg.sv
// Purpose: Shared types, constants and the code mapping of the differential converter readout.
// Assumes: Analog inputs arrive as signed numbers in units of half a result step.
// Notes: Serial pins are sampled by the system clock; no second clock domain exists.
package dasr_pkg;

  // Result word and bit positions
  localparam int RESULT_W = 12;
  localparam logic [3:0] IDX_MSB = 4'hB;
  localparam logic [3:0] IDX_ASC_FIRST = 4'h1;
  localparam logic [3:0] IDX_ASC_END = 4'hC;
  localparam logic [3:0] IDX_LSB = 4'h0;
  // Falls counted before the output driver turns on (second fall has index 1)
  localparam logic [1:0] ACQ_LAST_FALL = 2'h1;
  localparam logic NULL_BIT = 1'b0;
  localparam logic [1:0] ACQ_FIRST_FALL = 2'h0;

  // Reset values of the pin and result registers
  localparam logic DOUT_RST = 1'b0;
  localparam logic OE_N_RST = 1'b1;
  localparam logic [11:0] RESULT_RST = 12'h000;

  // Two's complement full scale codes
  localparam logic [11:0] CODE_POS_FS = 12'h7FF;
  localparam logic [11:0] CODE_NEG_FS = 12'h800;

  // Saturation thresholds in half steps: +2046.5 and -2047.5 steps
  localparam logic signed [16:0] SAT_POS_H = 17'sh0_0FFD;
  localparam logic signed [16:0] SAT_NEG_H = -17'sh0_0FFF;

  typedef struct packed {
    logic sclk;
    logic cs_n;
  } dasr_pins_t;

  typedef struct packed {
    logic signed [15:0] pos;
    logic signed [15:0] neg;
  } dasr_ain_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ACQ = 5'h02,
    ST_DESC = 5'h04,
    ST_ASC = 5'h08,
    ST_DONE = 5'h10
  } dasr_state_t;

  // Difference of the two inputs in half steps, widened so it never wraps
  function automatic logic signed [16:0] dasr_diff(input dasr_ain_t a);
    dasr_diff = 17'(a.pos) - 17'(a.neg);
  endfunction : dasr_diff

  // Ideal code: round to nearest step, then saturate at both full scales
  function automatic logic [11:0] dasr_code(input dasr_ain_t a);
    logic signed [16:0] d;
    logic signed [16:0] r;
    d = dasr_diff(a);
    r = (d + 17'sd1) >>> 1;
    if (d >= SAT_POS_H) begin
      dasr_code = CODE_POS_FS;
    end else if (d <= SAT_NEG_H) begin
      dasr_code = CODE_NEG_FS;
    end else begin
      dasr_code = r[11:0];
    end
  endfunction : dasr_code

endpackage : dasr_pkg

// >>> rtl/dasr_readout.sv
// Purpose: Conversion sequencing and serial result readout of a 12-bit differential converter.
// Assumes: Serial clock and chip select are synchronous to clk and much slower than it.
// Notes: The output pin is an output with enable; the enable is low while the pin is driven.
`timescale 1ns/1ns

module dasr_readout (
  input wire logic clk,
  input wire logic arst_n,
  input wire dasr_pkg::dasr_pins_t pins,
  input wire dasr_pkg::dasr_ain_t ain,
  output logic dout,
  output logic dout_oe_n
);
  import dasr_pkg::*;

  dasr_state_t state_reg;
  logic sclk_prev_reg;
  logic cs_n_prev_reg;
  logic [1:0] fall_cnt_reg;
  logic [3:0] bit_idx_reg;
  logic [11:0] result_reg;
  logic dout_reg;
  logic dout_oe_n_reg;
  logic sclk_fall;
  logic cs_fall;
  logic active;
  logic capture;
  logic exp_bit;

  // Edge detection on the sampled pins
  assign sclk_fall = sclk_prev_reg & ~pins.sclk;
  assign cs_fall = cs_n_prev_reg & ~pins.cs_n;
  // Clock falls only count while selected and not on the selecting cycle
  assign active = ~pins.cs_n & ~cs_fall & sclk_fall;
  assign capture = active && state_reg == ST_ACQ && fall_cnt_reg == ACQ_LAST_FALL;
  // Result bit at the shift position; index twelve only marks the resend end,
  // so it maps to a fixed level instead of reading past the word
  always_comb begin
    exp_bit = 1'b0;
    if (bit_idx_reg <= IDX_MSB) begin
      exp_bit = result_reg[bit_idx_reg];
    end
  end

  assign dout = dout_reg;
  assign dout_oe_n = dout_oe_n_reg;

  // Previous pin levels; idle levels chosen so reset looks deselected
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_reg <= 1'b0;
      cs_n_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= pins.sclk;
      cs_n_prev_reg <= pins.cs_n;
    end
  end

  // Sequencer: acquire, descending shift, ascending resend, done
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      fall_cnt_reg <= ACQ_FIRST_FALL;
      bit_idx_reg <= IDX_MSB;
    end else if (pins.cs_n) begin
      state_reg <= ST_IDLE;
    end else if (cs_fall && state_reg == ST_IDLE) begin
      state_reg <= ST_ACQ;
      fall_cnt_reg <= ACQ_FIRST_FALL;
    end else if (active) begin
      unique case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_IDLE;
        end
        ST_ACQ: begin
          if (fall_cnt_reg == ACQ_LAST_FALL) begin
            state_reg <= ST_DESC;
            bit_idx_reg <= IDX_MSB;
          end else begin
            fall_cnt_reg <= fall_cnt_reg + 2'h1;
          end
        end
        ST_DESC: begin
          if (bit_idx_reg == IDX_LSB) begin
            state_reg <= ST_ASC;
            bit_idx_reg <= IDX_ASC_FIRST;
          end else begin
            bit_idx_reg <= bit_idx_reg - 4'h1;
          end
        end
        ST_ASC: begin
          if (bit_idx_reg == IDX_ASC_END) begin
            state_reg <= ST_DONE;
          end else begin
            bit_idx_reg <= bit_idx_reg + 4'h1;
          end
        end
        ST_DONE: begin
          state_reg <= ST_DONE;
        end
      endcase
    end
  end

  // Sample is held from the second fall; track-and-hold closes there
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_reg <= RESULT_RST;
    end else if (capture) begin
      result_reg <= dasr_code(ain);
    end
  end

  // Output data bit, launched only on falling serial clock edges and cleared to its reset level on deselect
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_reg <= DOUT_RST;
    end else if (pins.cs_n) begin
      dout_reg <= DOUT_RST;
    end else if (active) begin
      if (capture) begin
        dout_reg <= NULL_BIT;
      end else if (state_reg == ST_DESC) begin
        dout_reg <= exp_bit;
      end else if (state_reg == ST_ASC && bit_idx_reg != IDX_ASC_END) begin
        dout_reg <= exp_bit;
      end
    end
  end

  // Driver enable; off at once on deselect, so a short cycle stops cleanly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_oe_n_reg <= OE_N_RST;
    end else if (pins.cs_n) begin
      dout_oe_n_reg <= 1'b1;
    end else if (capture) begin
      dout_oe_n_reg <= 1'b0;
    end else if (active && state_reg == ST_ASC && bit_idx_reg == IDX_ASC_END) begin
      dout_oe_n_reg <= 1'b1;
    end
  end

  // Checks of the sequencing against its causes

  sequence s_select;
    cs_n_prev_reg && !pins.cs_n;
  endsequence

  sequence s_second_fall;
    state_reg == ST_ACQ && fall_cnt_reg == ACQ_LAST_FALL && active;
  endsequence

  sequence s_first_fall;
    state_reg == ST_ACQ && fall_cnt_reg == ACQ_FIRST_FALL && active;
  endsequence

  sequence s_desc_step;
    state_reg == ST_DESC && active;
  endsequence

  sequence s_asc_step;
    state_reg == ST_ASC && bit_idx_reg != IDX_ASC_END && active;
  endsequence

  a_launch_on_fall: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(dout_reg) |-> $past(sclk_fall) || $past(pins.cs_n))
    else $error("output bit changed without a clock fall");

  a_select_starts: assert property (@(posedge clk) disable iff (!arst_n)
    (s_select ##0 (state_reg == ST_IDLE)) |=> state_reg == ST_ACQ && dout_oe_n_reg)
    else $error("chip select fall did not start acquisition");

  a_acq_output_off: assert property (@(posedge clk) disable iff (!arst_n)
    state_reg == ST_ACQ |-> dout_oe_n_reg)
    else $error("output driven during acquisition");

  a_enable_null_bit: assert property (@(posedge clk) disable iff (!arst_n)
    s_second_fall |=> !dout_oe_n_reg && dout_reg == NULL_BIT && state_reg == ST_DESC)
    else $error("second fall did not enable output with null bit");

  a_msb_third_fall: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == ST_DESC && bit_idx_reg == IDX_MSB && active) |=> dout_reg == result_reg[11])
    else $error("third fall did not present the top bit");

  a_bit_order: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg inside {ST_DESC, ST_ASC} && bit_idx_reg != IDX_ASC_END && active)
      |=> dout_reg == $past(exp_bit) && !dout_oe_n_reg)
    else $error("output bit does not match its result position");

  a_lsb_once: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == ST_DESC && bit_idx_reg == IDX_LSB && active)
      |=> state_reg == ST_ASC && bit_idx_reg == IDX_ASC_FIRST)
    else $error("ascending resend did not start at bit one");

  a_resend_end_hiz: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == ST_ASC && bit_idx_reg == IDX_ASC_END && active) |=> dout_oe_n_reg && state_reg == ST_DONE)
    else $error("output not released after the resend");

  a_deselect_hiz: assert property (@(posedge clk) disable iff (!arst_n)
    pins.cs_n |=> dout_oe_n_reg && state_reg == ST_IDLE)
    else $error("output driven while deselected");

  a_done_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == ST_DONE && !pins.cs_n) |=> state_reg == ST_DONE && $stable(dout_reg) && dout_oe_n_reg)
    else $error("clock edges disturbed a finished transfer");

  a_restart_needs_high: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == ST_ACQ && $past(state_reg) != ST_ACQ) |-> $past(cs_n_prev_reg) && !$past(pins.cs_n))
    else $error("conversion started without chip select toggle");

  a_pos_saturate: assert property (@(posedge clk) disable iff (!arst_n)
    (capture && dasr_diff(ain) >= SAT_POS_H) |=> result_reg == CODE_POS_FS)
    else $error("positive full scale not saturated");

  a_neg_saturate: assert property (@(posedge clk) disable iff (!arst_n)
    (capture && dasr_diff(ain) <= SAT_NEG_H) |=> result_reg == CODE_NEG_FS)
    else $error("negative full scale not saturated");

  a_zero_code: assert property (@(posedge clk) disable iff (!arst_n)
    (capture && ain.pos == ain.neg) |=> result_reg == RESULT_RST)
    else $error("equal inputs did not give code zero");

  a_idle_ignores: assert property (@(posedge clk) disable iff (!arst_n)
    (pins.cs_n && sclk_fall) |=> dout_oe_n_reg && $stable(result_reg))
    else $error("clock activity acted while deselected");

  // Counter steps, sample holding and output quiet between counted falls

  a_first_fall_counts: assert property (@(posedge clk) disable iff (!arst_n)
    s_first_fall
      |=> state_reg == ST_ACQ && fall_cnt_reg == ACQ_LAST_FALL && dout_oe_n_reg && $stable(result_reg))
    else $error("first clock fall did not advance acquisition");

  a_sample_held: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg inside {ST_DESC, ST_ASC, ST_DONE})
      |=> $stable(result_reg))
    else $error("held sample changed after acquisition");

  a_desc_steps_down: assert property (@(posedge clk) disable iff (!arst_n)
    (s_desc_step ##0 (bit_idx_reg != IDX_LSB))
      |=> state_reg == ST_DESC && bit_idx_reg == $past(bit_idx_reg) - 4'h1)
    else $error("descending shift skipped or repeated a bit");

  a_asc_steps_up: assert property (@(posedge clk) disable iff (!arst_n)
    s_asc_step
      |=> state_reg == ST_ASC && bit_idx_reg == $past(bit_idx_reg) + 4'h1)
    else $error("ascending resend skipped or repeated a bit");

  a_resend_bit_one: assert property (@(posedge clk) disable iff (!arst_n)
    (s_asc_step ##0 (bit_idx_reg == IDX_ASC_FIRST))
      |=> dout_reg == result_reg[1] && !dout_oe_n_reg)
    else $error("resend did not begin with bit one");

  a_quiet_between_falls: assert property (@(posedge clk) disable iff (!arst_n)
    (!pins.cs_n && !sclk_fall)
      |=> $stable(dout_reg) && $stable(dout_oe_n_reg))
    else $error("output moved between serial clock falls");

  a_driven_while_shifting: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg inside {ST_DESC, ST_ASC})
      |-> !dout_oe_n_reg)
    else $error("output released while result bits are due");

  a_enable_on_capture: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(dout_oe_n_reg)
      |-> $past(capture))
    else $error("output enabled away from the second clock fall");

  a_busy_while_low: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg != ST_IDLE && !pins.cs_n)
      |=> state_reg != ST_IDLE)
    else $error("conversion restarted without a chip select toggle");

  a_idle_output_off: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == ST_IDLE)
      |-> dout_oe_n_reg && dout_reg == DOUT_RST)
    else $error("output active while idle");

  a_deselect_dout_low: assert property (@(posedge clk) disable iff (!arst_n)
    pins.cs_n
      |=> dout_reg == DOUT_RST)
    else $error("data bit left standing after deselect");

endmodule : dasr_readout

// >>> test/dasr_host_model.sv
// Purpose: Host side of the serial readout: frames, serial clock, bit capture.
// Assumes: Pins change 1 ns after a clk edge; half periods are counted in clk cycles.
// Notes: Chip select rises together with the last clock fall, so no trailing fall lands in the frame.
`timescale 1ns/1ns
module dasr_host_model (
  input wire logic clk,
  input wire logic dout,
  input wire logic dout_oe_n,
  output dasr_pkg::dasr_pins_t pins
);
  import dasr_pkg::*;
  logic [1:0] cap [0:31];
  int nf;
  int unstable;
  // Idle: deselected, clock low and still
  initial begin
    pins = '{sclk: 1'b0, cs_n: 1'b1};
    nf = 0;
    unstable = 0;
  end
  task automatic hold(input int half);
    repeat (half) @(posedge clk);
    #1;
  endtask : hold
  // Bit k is the pin state taken on the rise after fall k
  task automatic frame(input int nfall, input int half);
    pins.cs_n = 1'b0;
    for (int j = 0; j <= nfall; j++) begin
      hold(half);
      pins.sclk = 1'b1;
      cap[j] = {dout_oe_n, dout};
      hold(half);
      if ({dout_oe_n, dout} !== cap[j]) unstable++;
      if (j == nfall) pins.cs_n = 1'b1;
      pins.sclk = 1'b0;
      nf++;
    end
    hold(half);
    nf = 0;
  endtask : frame
  // Clock runs while deselected; the converter must not react
  task automatic idle(input int n);
    for (int j = 0; j < 2 * n; j++) begin
      hold(2);
      pins.sclk = ~pins.sclk;
    end
  endtask : idle
endmodule : dasr_host_model

// >>> test/dasr_readout_tb.sv
// Purpose: Self-checking bench of the serial readout against the host model.
// Assumes: Input units are half result steps, as in the package.
// Notes: The input is disturbed after the second fall to prove the sample is held.
`timescale 1ns/1ns
module dasr_readout_tb;
  import dasr_pkg::*;
  logic clk;
  logic arst_n;
  dasr_pins_t pins;
  dasr_ain_t ain;
  logic dout;
  logic dout_oe_n;
  int error_cnt;
  int tests_run;
  dasr_readout dasr_readout_i (.clk(clk), .arst_n(arst_n), .pins(pins), .ain(ain), .dout(dout),
    .dout_oe_n(dout_oe_n));
  dasr_host_model dasr_host_model_i (.clk(clk), .dout(dout), .dout_oe_n(dout_oe_n), .pins(pins));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_of_test;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  // Expected {oe_n, bit} after fall k; oe_n high means dout is not looked at
  function automatic logic [1:0] exp_pin(input logic [11:0] code, input int k);
    if (k < 2 || k >= 26) return 2'b10;
    if (k == 2) return 2'b00;
    if (k <= 14) return {1'b0, code[14 - k]};
    return {1'b0, code[k - 14]};
  endfunction : exp_pin
  // One conversion, nfall falls, then deselect and compare every captured bit
  task automatic conv(input logic signed [15:0] p, input logic signed [15:0] n, input logic [11:0] code,
    input int nfall, input int half);
    logic [1:0] e;
    logic [1:0] c;
    ain = '{pos: p, neg: n};
    fork
      dasr_host_model_i.frame(nfall, half);
      begin
        for (int i = 0; i < 400 && dasr_host_model_i.nf < 2; i++) @(posedge clk);
        if (dasr_host_model_i.nf < 2) error_cnt++;
        #1 ain = '{pos: 16'sh0123, neg: 16'sh0ABC};
      end
    join
    for (int k = 0; k <= nfall; k++) begin
      e = exp_pin(code, k);
      c = dasr_host_model_i.cap[k];
      if (e[1]) chk("oe_n in frame", {15'h0, c[1]}, 16'h0001);
      else chk("frame bit", {14'h0, c}, {14'h0, e});
    end
    chk("oe_n after frame", {15'h0, dout_oe_n}, 16'h0001);
    chk("bit held while high", 16'(dasr_host_model_i.unstable), 16'h0000);
  endtask : conv
  task automatic idle_check;
    fork
      dasr_host_model_i.idle(4);
      repeat (16) begin
        @(posedge clk);
        #1 chk("idle oe_n", {15'h0, dout_oe_n}, 16'h0001);
      end
    join
  endtask : idle_check
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
  // Main sequence: back to back frames, full, double, short and slow
  initial begin
    error_cnt = 0;
    tests_run = 0;
    arst_n = 1'b0;
    ain = '{pos: 16'sh0000, neg: 16'sh0000};
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    idle_check();
    conv(16'sd4093, 16'sd0, 12'h7FF, 28, 2);
    conv(16'sd4092, 16'sd0, 12'h7FE, 26, 3);
    conv(16'sd0, 16'sd0, 12'h000, 14, 2);
    idle_check();
    conv(16'sd0, 16'sd2, 12'hFFF, 15, 5);
    conv(16'sd0, 16'sd4095, 12'h800, 26, 2);
    conv(16'sd0, 16'sd4094, 12'h801, 20, 2);
    conv(16'sd100, 16'sd40, 12'h01E, 14, 2);
    end_of_test();
  end
endmodule : dasr_readout_tb
